// >>> hdl/ascw_pkg.sv
// Shared types and constants of the serial control-word block
package ascw_pkg;

  // ==========================================================
  // Frame geometry
  localparam int CW_W = 12;
  localparam int FRAME_LEN = 16;
  localparam int RES_W = 12;
  localparam int CNT_W = 5;
  localparam int WRITE_POS = 11;
  localparam logic [CNT_W-1:0] CFG_EDGES = 5'h0c;
  localparam logic [CNT_W-1:0] MUX_EDGE = 5'h0e;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10;
  localparam logic [1:0] LEAD_ZEROS = 2'h0;

  // ==========================================================
  // Field encodings
  typedef enum logic [1:0] {
    PM_INVALID = 2'b00,
    PM_AUTO = 2'b01,
    PM_FULL_SD = 2'b10,
    PM_NORMAL = 2'b11
  } ascw_pm_e;

  typedef enum logic [1:0] {
    SQ_SINGLE = 2'b00,
    SQ_SHADOW = 2'b01,
    SQ_KEEP = 2'b10,
    SQ_CONSEC = 2'b11
  } ascw_seq_e;

  // Stored setup word, bits 10..0 of the serial word
  typedef struct packed {
    logic sequence_enable;
    logic ignored_bit9;
    logic [2:0] channel_address;
    ascw_pm_e power_mode;
    logic shadow_select;
    logic ignored_bit2;
    logic range_ref;
    logic straight_bin;
  } ascw_cfg_s;

  // Full power, channel 0, double range, twos complement
  localparam logic [CW_W-2:0] CFG_RST = 11'h030;
  localparam logic [FRAME_LEN-1:0] SHADOW_RST = 16'h0000;

  // Words and flags handed from the serial-clock side
  typedef struct packed {
    logic [CW_W-1:0] cfg_word;
    logic [FRAME_LEN-1:0] full_word;
    logic got_cfg;
    logic got_all;
  } ascw_link_s;

endpackage

// >>> hdl/ascw_sync.sv
// Two-flop level synchroniser into the system clock
`timescale 1ns/1ps
module ascw_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_rst_val,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ascw_sync_s;

  ascw_sync_s q;
  ascw_sync_s d;

  // The first stage feeds only the second stage
  always_comb begin
    d.meta = i_async;
    d.sync = q.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Start at the idle level of each input so no false edge follows reset
      q <= '{meta: i_rst_val, sync: i_rst_val};
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_sync = q.sync;
endmodule

// >>> hdl/ascw_link.sv
// Serial-clock side: bit counter, input shifter and output bit stream
`timescale 1ns/1ps
module ascw_link
  import ascw_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic [FRAME_LEN-1:0] i_out_word,
  output logic o_dout,
  output ascw_pkg::ascw_link_s o_link
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [FRAME_LEN-2:0] sh;
    logic dout;
    logic got_cfg;
    logic got_all;
  } ascw_lctl_s;

  typedef struct packed {
    logic [CW_W-1:0] cfg_word;
    logic [FRAME_LEN-1:0] full_word;
  } ascw_lhold_s;

  ascw_lctl_s q;
  ascw_lctl_s d;
  ascw_lhold_s hq;
  ascw_lhold_s hd;

  // ==========================================================
  // Next state; edges past the sixteenth are ignored
  always_comb begin
    d = q;
    hd = hq;
    if (q.cnt < FRAME_EDGES) begin
      d.cnt = q.cnt + 5'h01;
      d.sh = {q.sh[FRAME_LEN-3:0], i_din};
      if (q.cnt < FRAME_EDGES - 5'h01) begin
        d.dout = i_out_word[4'(FRAME_LEN - 2) - q.cnt[3:0]];
      end else begin
        d.dout = 1'b0;
      end
      if (q.cnt == CFG_EDGES - 5'h01) begin
        hd.cfg_word = {q.sh[CW_W-2:0], i_din};
      end
      if (q.cnt == MUX_EDGE - 5'h01) begin
        d.got_cfg = 1'b1;
      end
      if (q.cnt == FRAME_EDGES - 5'h01) begin
        hd.full_word = {q.sh, i_din};
        d.got_all = 1'b1;
      end
    end
  end

  // Chip select high ends the frame even while the serial clock stands still
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Held words outlive the frame so the system side can read them
  always_ff @(negedge i_sclk) begin
    hq <= hd;
  end

  assign o_dout = q.dout;
  assign o_link = {hq.cfg_word, hq.full_word, q.got_cfg, q.got_all};
endmodule

// >>> hdl/ascw_top.sv
// Serial setup-word logic of an eight-input converter, system-clock side
// ==========================================================
// What this block does
// - Holds a 12-bit setup word shifted in MSB first on falling serial clock.
// - Setup bits enter while the result leaves and apply to the next conversion.
// - Only the first twelve falling edges after select feed the setup word.
// - Bit 11 set outside a shadow frame loads bits 10..0, ignored bits 9 and 2 as zero; clear leaves word unchanged.
// - Sequence and shadow bits together choose sequencing and shadow access.
// - Channel address bits take effect at end of the present conversion.
// - Address value n selects analog input n, zero through seven.
// - Low two bits of the current result's channel tag go out before its twelve bits.
// - Multiplexer moves to the next channel on the fourteenth falling edge.
// - Power mode 11 keeps the converter fully powered.
// - Power mode 10 powers down, keeps the word, until mode is rewritten.
// - Power mode 01 shuts down after each conversion that updated the word.
// - Range bit 0 gives twice-reference span, 1 gives reference span.
// - Coding bit 0 gives twos complement, 1 gives straight binary.
// - Output frame: two zeros, low two channel tag bits, twelve result bits MSB first.
// - Sequence 0 with shadow 1 makes the next frame a shadow word.
`timescale 1ns/1ps
module ascw_top
  import ascw_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_DIN,
  input wire logic [ascw_pkg::RES_W-1:0] I_RESULT,
  output logic O_DOUT,
  output ascw_pkg::ascw_cfg_s O_CFG,
  output logic [2:0] O_MUX_CHAN,
  output logic [2:0] O_RESULT_TAG,
  output logic O_POWER_DOWN,
  output logic [ascw_pkg::FRAME_LEN-1:0] O_SHADOW_WORD
);
  typedef struct packed {
    ascw_cfg_s cfg;
    logic [2:0] chan;
    logic [2:0] last;
    logic [2:0] tag;
    logic [FRAME_LEN-1:0] out_word;
    logic [FRAME_LEN-1:0] shadow;
    logic shadow_arm;
    logic fshadow;
    logic upd;
    logic auto_pd;
    logic pdown;
    logic csn_p;
    logic cfg_p;
    logic all_p;
  } ascw_sys_s;

  // Previous chip-select level starts high so reset never looks like a frame start
  localparam ascw_sys_s SYS_RST = '{
    cfg: ascw_cfg_s'(CFG_RST),
    shadow: SHADOW_RST,
    csn_p: 1'b1,
    default: '0
  };

  ascw_sys_s q;
  ascw_sys_s d;
  ascw_link_s link;
  ascw_cfg_s newcfg;
  ascw_cfg_s applied;
  logic [2:0] sync_out;
  logic csn_s;
  logic cfg_s;
  logic all_s;
  logic cs_fall;
  logic ev14;
  logic ev16;

  // ==========================================================
  // Serial-clock side
  ascw_link u_link (
    .i_sclk(I_SCLK),
    .i_cs_n(I_CS_N),
    .i_din(I_DIN),
    .i_out_word(q.out_word),
    .o_dout(O_DOUT),
    .o_link(link)
  );

  // ==========================================================
  // Crossing: levels are synchronised; the held words are only read
  // after their flag has crossed, and stay put until the next frame
  ascw_sync #(.W(3)) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_rst_val(3'h4),
    .i_async({I_CS_N, link.got_cfg, link.got_all}),
    .o_sync(sync_out)
  );

  assign csn_s = sync_out[2];
  assign cfg_s = sync_out[1];
  assign all_s = sync_out[0];
  // Edge detectors start at their inputs' idle levels; no event follows reset
  assign cs_fall = q.csn_p & ~csn_s;
  assign ev14 = cfg_s & ~q.cfg_p;
  assign ev16 = all_s & ~q.all_p;

  // ==========================================================
  // Setup word, channel stepping and power state
  always_comb begin
    d = q;
    d.csn_p = csn_s;
    d.cfg_p = cfg_s;
    d.all_p = all_s;
    newcfg = ascw_cfg_s'(link.cfg_word[CW_W-2:0]);
    newcfg.ignored_bit9 = 1'b0;
    newcfg.ignored_bit2 = 1'b0;
    applied = q.cfg;
    if (cs_fall) begin
      // The result of the channel now converting leaves in this frame
      d.out_word = {LEAD_ZEROS, q.chan[1:0], I_RESULT};
      d.tag = q.chan;
      d.fshadow = q.shadow_arm;
      d.upd = 1'b0;
      d.auto_pd = 1'b0;
    end
    if (ev14 && !q.fshadow) begin
      if (link.cfg_word[WRITE_POS]) begin
        applied = newcfg;
        d.cfg = newcfg;
        d.upd = 1'b1;
        d.shadow_arm = ({newcfg.sequence_enable, newcfg.shadow_select} == SQ_SHADOW);
      end
      // Without a write the stored mode still steps the channel
      case (ascw_seq_e'({applied.sequence_enable, applied.shadow_select}))
        SQ_CONSEC: begin
          d.last = applied.channel_address;
          d.chan = (q.chan >= applied.channel_address) ? 3'h0 : q.chan + 3'h1;
        end
        SQ_KEEP: begin
          d.chan = (q.chan >= q.last) ? 3'h0 : q.chan + 3'h1;
        end
        default: begin
          d.chan = applied.channel_address;
        end
      endcase
    end
    if (ev16) begin
      if (q.fshadow) begin
        d.shadow = link.full_word;
        d.shadow_arm = 1'b0;
      end
      if (q.upd && q.cfg.power_mode == PM_AUTO) begin
        d.auto_pd = 1'b1;
      end
    end
    // Full shutdown holds while the mode stays; auto shutdown wakes on select
    d.pdown = (d.cfg.power_mode == PM_FULL_SD) ||
              (d.auto_pd && d.cfg.power_mode == PM_AUTO);
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      q <= SYS_RST;
    end else if (I_CE) begin
      q <= d;
    end
  end

  // Range and coding bits leave as fields of the setup word
  assign O_CFG = q.cfg;
  assign O_MUX_CHAN = q.chan;
  assign O_RESULT_TAG = q.tag;
  assign O_POWER_DOWN = q.pdown;
  assign O_SHADOW_WORD = q.shadow;

  // ==========================================================
  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  write_load_a: assert property (ev14 && I_CE && !q.fshadow && link.cfg_word[WRITE_POS] |=>
    q.cfg == ascw_cfg_s'({$past(link.cfg_word[10]), 1'b0, $past(link.cfg_word[8:3]), 1'b0,
                          $past(link.cfg_word[1:0])}))
    else $error("setup word not loaded from serial word");

  write_gate_a: assert property (ev14 && I_CE && !link.cfg_word[WRITE_POS] |=> $stable(q.cfg))
    else $error("setup word changed with write bit clear");

  no_cfg_change_a: assert property (!ev14 |=> $stable(q.cfg))
    else $error("setup word changed outside the fourteenth edge");

  ignored_bits_a: assert property (!O_CFG.ignored_bit9 && !O_CFG.ignored_bit2)
    else $error("ignored bits stored");

  mux_moment_a: assert property (!(ev14 && I_CE) |=> $stable(O_MUX_CHAN))
    else $error("channel moved without a fourteenth edge");

  chan_decode_a: assert property (ev14 && I_CE && !q.fshadow && link.cfg_word[WRITE_POS] &&
    link.cfg_word[10] == 1'b0 |=> O_MUX_CHAN == $past(link.cfg_word[8:6]))
    else $error("channel address decoded wrongly");

  out_frame_a: assert property (cs_fall && I_CE |=> q.out_word[15:14] == LEAD_ZEROS &&
    q.out_word[13:12] == $past(q.chan[1:0]) && q.out_word[11:0] == $past(I_RESULT))
    else $error("output frame misassembled");

  tag_a: assert property (cs_fall && I_CE |=> O_RESULT_TAG == $past(O_MUX_CHAN))
    else $error("result tag is not the converting channel");

  normal_pw_a: assert property (O_CFG.power_mode == PM_NORMAL |-> !O_POWER_DOWN)
    else $error("powered down in normal mode");

  full_sd_a: assert property (O_CFG.power_mode == PM_FULL_SD |-> O_POWER_DOWN)
    else $error("not down in full shutdown");

  auto_sd_a: assert property (ev16 && I_CE && q.upd && O_CFG.power_mode == PM_AUTO |=>
    O_POWER_DOWN ##1 (O_POWER_DOWN || $past(cs_fall)))
    else $error("auto shutdown missed");

  shadow_load_a: assert property (ev16 && I_CE && q.fshadow |=> O_SHADOW_WORD == $past(link.full_word))
    else $error("shadow word not loaded");

  shadow_keep_a: assert property (ev14 && q.fshadow |=> $stable(q.cfg))
    else $error("shadow frame altered setup word");

  // ==========================================================
  // Channel stepping without a write, and the final channel a write stores; a shadow frame leaves it alone
  consec_step_a: assert property (ev14 && I_CE && !q.fshadow && !link.cfg_word[WRITE_POS] &&
    q.cfg.sequence_enable && q.cfg.shadow_select && q.chan < q.cfg.channel_address |=>
    O_MUX_CHAN == $past(q.chan) + 3'h1)
    else $error("consecutive sequence did not step");

  consec_wrap_a: assert property (ev14 && I_CE && !q.fshadow && !link.cfg_word[WRITE_POS] &&
    q.cfg.sequence_enable && q.cfg.shadow_select && q.chan >= q.cfg.channel_address |=>
    O_MUX_CHAN == 3'h0)
    else $error("consecutive sequence did not wrap to channel zero");

  keep_step_a: assert property (ev14 && I_CE && !q.fshadow && !link.cfg_word[WRITE_POS] &&
    q.cfg.sequence_enable && !q.cfg.shadow_select |=>
    O_MUX_CHAN == (($past(q.chan) >= $past(q.last)) ? 3'h0 : $past(q.chan) + 3'h1))
    else $error("kept sequence did not continue");

  single_sel_a: assert property (ev14 && I_CE && !q.fshadow && !link.cfg_word[WRITE_POS] &&
    !q.cfg.sequence_enable |=> O_MUX_CHAN == $past(q.cfg.channel_address))
    else $error("stored channel address not applied");

  last_chan_a: assert property (ev14 && I_CE && !q.fshadow && link.cfg_word[WRITE_POS] &&
    link.cfg_word[10] && link.cfg_word[3] |=> q.last == $past(link.cfg_word[8:6]))
    else $error("final channel of the sequence not stored");

  shadow_mux_a: assert property (ev14 && I_CE && q.fshadow |=> $stable(O_MUX_CHAN))
    else $error("shadow frame moved the channel");

  mux_once_a: assert property (ev14 && I_CE |=> !ev14)
    else $error("fourteenth-edge event lasted more than one cycle");

  // ==========================================================
  // Fields taken from a written word
  upd_flag_a: assert property (ev14 && I_CE && !q.fshadow |=> q.upd == $past(link.cfg_word[WRITE_POS]))
    else $error("update flag does not follow the write bit");

  range_code_a: assert property (ev14 && I_CE && !q.fshadow && link.cfg_word[WRITE_POS] |=>
    O_CFG.range_ref == $past(link.cfg_word[1]) && O_CFG.straight_bin == $past(link.cfg_word[0]))
    else $error("range or coding bit not taken from the serial word");

  power_field_a: assert property (ev14 && I_CE && !q.fshadow && link.cfg_word[WRITE_POS] |=>
    O_CFG.power_mode == $past(link.cfg_word[5:4]))
    else $error("power mode bits not taken from the serial word");

  shadow_arm_a: assert property (ev14 && I_CE && !q.fshadow && link.cfg_word[WRITE_POS] &&
    !link.cfg_word[10] && link.cfg_word[3] |=> q.shadow_arm)
    else $error("shadow access not armed");

  shadow_frame_a: assert property (cs_fall && I_CE |=> q.fshadow == $past(q.shadow_arm))
    else $error("armed shadow access not applied to the frame");

  // ==========================================================
  // Outputs that move only at their own event
  tag_hold_a: assert property (!(cs_fall && I_CE) |=> $stable(O_RESULT_TAG))
    else $error("result tag changed between frames");

  word_hold_a: assert property (!(cs_fall && I_CE) |=> $stable(q.out_word))
    else $error("output word changed while it was being shifted");

  shadow_hold_a: assert property (!(ev16 && I_CE) |=> $stable(O_SHADOW_WORD))
    else $error("shadow word changed without a sixteenth edge");

  full_sd_hold_a: assert property (O_CFG.power_mode == PM_FULL_SD && !ev14 |=> O_POWER_DOWN)
    else $error("left full shutdown without a mode change");

  auto_wake_a: assert property (cs_fall && I_CE && O_CFG.power_mode == PM_AUTO |=> !O_POWER_DOWN)
    else $error("no wake on frame start after automatic shutdown");

  auto_noupd_a: assert property (ev16 && I_CE && !q.upd && !O_POWER_DOWN |=> !O_POWER_DOWN)
    else $error("automatic shutdown without a setup update");

  write_cov_c: cover property (ev14 && link.cfg_word[WRITE_POS] ##[1:200] ev16);
  shadow_cov_c: cover property (ev16 && q.fshadow);
  auto_cov_c: cover property (O_CFG.power_mode == PM_AUTO && O_POWER_DOWN);
  wrap_cov_c: cover property (ev14 && q.cfg.sequence_enable && q.cfg.shadow_select ##1 O_MUX_CHAN == 3'h0);
  keep_cov_c: cover property (ev14 && q.cfg.sequence_enable && !q.cfg.shadow_select);
endmodule

// >>> bench/ascw_host.sv
// Host serial port model: frames sixteen serial clocks, sends a word, gathers the reply
`timescale 1ns/1ps
module ascw_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout
);
  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // ==========================================================
  // One transfer; serial clock stands high between frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7;
    o_cs_n = 1'b0;
    o_din = tx[15];
    #400;
    for (int i = 15; i >= 0; i--) begin
      rx[i] = i_dout;
      o_sclk = 1'b0;
      #80;
      // Released data line shows the inverse, never a stale copy
      o_din = (i > 0) ? tx[i-1] : ~tx[0];
      o_sclk = 1'b1;
      #80;
    end
    #200;
    o_cs_n = 1'b1;
    // Gap also covers the wake-up time after an automatic shutdown
    #1200;
  endtask
endmodule

// >>> bench/ascw_top_tb.sv
// Self-checking bench of the serial setup-word block
`timescale 1ns/1ps
module ascw_top_tb;
  import ascw_pkg::*;
  logic clk, rst, ce, sclk, cs_n, din, dout, pd;
  logic [RES_W-1:0] result;
  ascw_cfg_s cfg, exp_cfg;
  logic [2:0] mux, tag, exp_mux;
  logic [FRAME_LEN-1:0] shadow, rx;
  int fail_count = 0;
  int samples_checked = 0;

  ascw_top ascw_top_i (.I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_DIN(din), .I_RESULT(result), .O_DOUT(dout), .O_CFG(cfg), .O_MUX_CHAN(mux),
    .O_RESULT_TAG(tag), .O_POWER_DOWN(pd), .O_SHADOW_WORD(shadow));
  ascw_host ascw_host_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // Shared helpers
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Ignored positions and the four trailing bits are sent as ones on purpose
  function automatic logic [15:0] cw(input logic wr, sq, input logic [2:0] ad, input logic [1:0] pm,
                                     input logic sh, rg, cd);
    return {wr, sq, 1'b1, ad, pm, sh, 1'b1, rg, cd, 4'hf};
  endfunction

  task automatic frame(input logic [15:0] w);
    @(negedge clk);
    result = w[15:4] ^ 12'h5a3;
    ascw_host_i.xfer(w, rx);
    chk("dout frame", {2'b00, exp_mux[1:0], result}, rx);
    chk("result tag", 16'(exp_mux), 16'(tag));
  endtask

  task automatic put(input logic wr, sq, input logic [2:0] ad, input logic [1:0] pm, input logic sh, rg, cd);
    frame(cw(wr, sq, ad, pm, sh, rg, cd));
    if (wr) begin
      exp_cfg = ascw_cfg_s'({sq, 1'b0, ad, pm, sh, 1'b0, rg, cd});
    end
    chk("setup word", 16'(exp_cfg), 16'(cfg));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("reset word", 16'(CFG_RST), 16'(cfg));
    chk("reset mux", 16'h0000, 16'(mux));
    chk("reset power", 16'h0000, 16'(pd));
    chk("reset shadow", SHADOW_RST, shadow);
    chk("reset tag", 16'h0000, 16'(tag));
  endtask

  task automatic t_chan();
    for (int a = 0; a < 8; a++) begin
      put(1'b1, 1'b0, 3'(a), 2'b11, 1'b0, a[0], ~a[0]);
      exp_mux = 3'(a);
      chk("mux chan", 16'(exp_mux), 16'(mux));
    end
  endtask

  task automatic t_nowrite();
    put(1'b0, 1'b1, 3'h2, 2'b10, 1'b1, 1'b0, 1'b0);
    chk("mux kept", 16'(exp_mux), 16'(mux));
    chk("power kept", 16'h0000, 16'(pd));
  endtask

  task automatic t_power();
    put(1'b1, 1'b0, 3'h1, 2'b10, 1'b0, 1'b0, 1'b0);
    exp_mux = 3'h1;
    chk("full down", 16'h0001, 16'(pd));
    put(1'b0, 1'b0, 3'h0, 2'b11, 1'b0, 1'b0, 1'b0);
    chk("still down", 16'h0001, 16'(pd));
    put(1'b1, 1'b0, 3'h1, 2'b01, 1'b0, 1'b0, 1'b0);
    chk("auto down", 16'h0001, 16'(pd));
    put(1'b0, 1'b0, 3'h0, 2'b11, 1'b0, 1'b0, 1'b0);
    chk("auto no write", 16'h0000, 16'(pd));
    put(1'b1, 1'b0, 3'h1, 2'b11, 1'b0, 1'b0, 1'b0);
    chk("normal up", 16'h0000, 16'(pd));
  endtask

  task automatic t_shadow();
    put(1'b1, 1'b0, 3'h2, 2'b11, 1'b1, 1'b1, 1'b1);
    exp_mux = 3'h2;
    // Top bit set: would be a write if taken as a setup word
    frame(16'h9c3a);
    chk("shadow word", 16'h9c3a, shadow);
    chk("setup untouched", 16'(exp_cfg), 16'(cfg));
  endtask

  task automatic t_seq();
    put(1'b1, 1'b1, 3'h2, 2'b11, 1'b1, 1'b0, 1'b0);
    exp_mux = 3'h0;
    chk("seq start", 16'(exp_mux), 16'(mux));
    for (int i = 1; i < 4; i++) begin
      put(1'b0, 1'b0, 3'h0, 2'b11, 1'b0, 1'b0, 1'b0);
      exp_mux = 3'(i % 3);
      chk("seq step", 16'(exp_mux), 16'(mux));
    end
    // Sequence kept going while other bits are rewritten
    put(1'b1, 1'b1, 3'h5, 2'b11, 1'b0, 1'b0, 1'b0);
    exp_mux = 3'h1;
    chk("keep step", 16'(exp_mux), 16'(mux));
    put(1'b0, 1'b0, 3'h0, 2'b11, 1'b0, 1'b0, 1'b0);
    exp_mux = 3'h2;
    chk("keep step", 16'(exp_mux), 16'(mux));
  endtask

  task automatic t_freeze();
    logic [15:0] was_rx;
    logic [2:0] was_tag;
    was_rx = rx;
    was_tag = tag;
    @(negedge clk);
    ce = 1'b0;
    // A whole frame while frozen: the serial side repeats the old word
    ascw_host_i.xfer(cw(1'b1, 1'b0, 3'h6, 2'b10, 1'b0, 1'b0, 1'b0), rx);
    @(negedge clk);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    chk("frozen dout", was_rx, rx);
    chk("frozen tag", 16'(was_tag), 16'(tag));
    chk("frozen word", 16'(exp_cfg), 16'(cfg));
    chk("frozen mux", 16'(exp_mux), 16'(mux));
    chk("frozen power", 16'h0000, 16'(pd));
  endtask

  task automatic t_midreset();
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    exp_cfg = ascw_cfg_s'(CFG_RST);
    exp_mux = 3'h0;
    repeat (3) @(negedge clk);
    t_reset();
    put(1'b1, 1'b0, 3'h3, 2'b11, 1'b0, 1'b1, 1'b0);
    exp_mux = 3'h3;
    chk("mux after reset", 16'(exp_mux), 16'(mux));
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    result = 12'h000;
    exp_cfg = ascw_cfg_s'(CFG_RST);
    exp_mux = 3'h0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_chan();
    t_nowrite();
    t_power();
    t_shadow();
    t_seq();
    t_freeze();
    t_midreset();
    summarize();
  end

  // About 25 frames of under 5 us each; generous margin
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
endmodule
